/* common/scc_pkg.sv */
// Constants and types shared by the sync and clock configuration block.
`default_nettype none
package scc_pkg;
  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 50;
  // Period of the slowest encode rate that still counts as normal (5 MSPS).
  localparam int LOW_RATE_PERIOD_NS = 200;
  localparam int LOW_RATE_CYC = LOW_RATE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int DET_CNT_W = 8;
  localparam logic [DET_CNT_W-1:0] DET_CNT_LIM =
    DET_CNT_W'(LOW_RATE_CYC);
  localparam logic [DET_CNT_W-1:0] DET_CNT_MAX = 8'hFF;

  // ==========================================================================
  // Serial port framing
  // ==========================================================================
  localparam int ADDR_W = 13;
  localparam logic [3:0] INSTR_LAST_BIT = 4'hF;
  localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
  localparam int INSTR_RW_BIT = 15;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [ADDR_W-1:0] SYNC_CONTROL_ADDR = 13'h0100;
  localparam logic [ADDR_W-1:0] USER_CLOCK_OPTIONS_ADDR = 13'h0101;
  localparam logic [7:0] SYNC_CONTROL_RESET = 8'h01;
  localparam logic [7:0] USER_CLOCK_OPTIONS_RESET = 8'h88;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // sync_control fields.
  localparam int MASTER_SYNC_BIT = 0;
  localparam int DIV_SYNC_EN_BIT = 1;
  localparam int ONE_SHOT_BIT = 2;
  localparam logic [7:0] SYNC_CONTROL_MASK = 8'h07;

  // user_clock_options fields.
  localparam int PULLDOWN_DIS_BIT = 0;
  localparam int OSC_RUN_BIT = 2;
  localparam int DETECT_EN_BIT = 3;
  localparam int OE_PIN_CTL_BIT = 7;
  localparam logic [7:0] USER_CLOCK_OPTIONS_MASK = 8'h8D;

  typedef enum logic [1:0] {
    SCC_SPI_INSTR,
    SCC_SPI_WDATA,
    SCC_SPI_RDATA
  } scc_spi_state_t;
endpackage
`default_nettype wire

/* common/scc_det_if.sv */
// Link between the register logic and the low encode rate detector.
`timescale 1ns/100ps
`default_nettype none
interface scc_det_if;
  logic detect_en;
  logic low_rate;

  modport ctl (
    output detect_en,
    input  low_rate
  );
  modport det (
    input  detect_en,
    output low_rate
  );
endinterface
`default_nettype wire

/* rtl/scc_rate_det.sv */
// Low encode rate detector measuring the encode clock pin in ref_clk cycles.
`timescale 1ns/100ps
`default_nettype none
module scc_rate_det (
  input  wire logic  ref_clk,
  input  wire logic  rst,
  input  wire logic  enc_clk_pin,
  scc_det_if.det     det
);
  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic                           enc_m;
    logic                           enc_s;
    logic                           enc_d;
    logic [scc_pkg::DET_CNT_W-1:0]  gap;
    logic                           low;
  } scc_det_state_t;

  scc_det_state_t st_reg;
  scc_det_state_t st_next;

  // ==========================================================================
  // Period measurement
  // ==========================================================================
  // The pin is only sampled at ref_clk, so an encode clock faster than about
  // half of ref_clk aliases; it can then read as slow even though it is not.
  always_comb begin
    st_next = st_reg;
    st_next.enc_m = enc_clk_pin;
    st_next.enc_s = st_reg.enc_m;
    st_next.enc_d = st_reg.enc_s;
    if (!det.detect_en) begin
      st_next.gap = '0;
      st_next.low = 1'b0;
    end else if (st_reg.enc_s && !st_reg.enc_d) begin
      st_next.low = (st_reg.gap >= scc_pkg::DET_CNT_LIM);
      st_next.gap = '0;
    end else begin
      if (st_reg.gap != scc_pkg::DET_CNT_MAX) begin
        st_next.gap = st_reg.gap + 1'b1;
      end
      // A stopped encode clock must also read as slow.
      if (st_reg.gap >= scc_pkg::DET_CNT_LIM) begin
        st_next.low = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign det.low_rate = st_reg.low;
endmodule
`default_nettype wire

/* rtl/scc_top.sv */
// Sync gating, housekeeping oscillator control and serial register port.
`timescale 1ns/100ps
`default_nettype none
module scc_top (
  input  wire logic  ref_clk,
  input  wire logic  rst,
  input  wire logic  sclk,
  input  wire logic  csb_n,
  input  wire logic  sdio_in,
  output logic       sdio_out,
  output logic       sdio_oe,
  output logic       sdio_pulldown_en,
  input  wire logic  sync_pin,
  output logic       divider_sync_pulse,
  input  wire logic  output_enable_n_pin,
  output logic       data_out_en,
  input  wire logic  enc_clk_pin,
  output logic       housekeeping_oscillator_on
);
  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic                         sclk_m;
    logic                         sclk_s;
    logic                         sclk_d;
    logic                         csb_m;
    logic                         csb_s;
    logic                         sdio_m;
    logic                         sdio_s;
    logic                         sync_m;
    logic                         sync_s;
    logic                         sync_d;
    logic                         oen_m;
    logic                         oen_s;
    scc_pkg::scc_spi_state_t      phase;
    logic [3:0]                   bit_cnt;
    logic [15:0]                  shift;
    logic [scc_pkg::ADDR_W-1:0]   addr;
    logic [7:0]                   rd_byte;
    logic                         sdio_out;
    logic                         sdio_oe;
    logic [7:0]                   sync_control;
    logic [7:0]                   user_clock_options;
    logic                         div_sync;
    logic                         out_en;
    logic                         osc_on;
  } scc_state_t;

  scc_state_t st_reg;
  scc_state_t st_next;

  scc_det_if det_link ();

  // ==========================================================================
  // Register read decode
  // ==========================================================================
  function automatic logic [7:0] reg_read(
    input logic [scc_pkg::ADDR_W-1:0] addr,
    input logic [7:0]                 sync_control,
    input logic [7:0]                 user_clock_options
  );
    logic [7:0] data;
    data = scc_pkg::UNMAPPED_READ;
    if (addr == scc_pkg::SYNC_CONTROL_ADDR) begin
      data = sync_control & scc_pkg::SYNC_CONTROL_MASK;
    end else if (addr == scc_pkg::USER_CLOCK_OPTIONS_ADDR) begin
      data = user_clock_options & scc_pkg::USER_CLOCK_OPTIONS_MASK;
    end
    return data;
  endfunction

  // ==========================================================================
  // Next state
  // ==========================================================================
  logic       sclk_rise;
  logic       sclk_fall;
  logic       sync_rise;
  logic       sync_armed;
  logic       wr_stb;
  logic [7:0] wr_byte;
  logic [15:0] shifted;

  always_comb begin
    st_next = st_reg;
    wr_stb = 1'b0;
    wr_byte = '0;

    // Pins are asynchronous to ref_clk; the first stage is never used directly.
    st_next.sclk_m = sclk;
    st_next.sclk_s = st_reg.sclk_m;
    st_next.sclk_d = st_reg.sclk_s;
    st_next.csb_m = csb_n;
    st_next.csb_s = st_reg.csb_m;
    st_next.sdio_m = sdio_in;
    st_next.sdio_s = st_reg.sdio_m;
    st_next.sync_m = sync_pin;
    st_next.sync_s = st_reg.sync_m;
    st_next.sync_d = st_reg.sync_s;
    st_next.oen_m = output_enable_n_pin;
    st_next.oen_s = st_reg.oen_m;

    sclk_rise = st_reg.sclk_s && !st_reg.sclk_d;
    sclk_fall = !st_reg.sclk_s && st_reg.sclk_d;
    sync_rise = st_reg.sync_s && !st_reg.sync_d;
    shifted = {st_reg.shift[14:0], st_reg.sdio_s};

    // Serial port: 16-bit instruction, then bytes with a falling address.
    if (st_reg.csb_s) begin
      st_next.phase = scc_pkg::SCC_SPI_INSTR;
      st_next.bit_cnt = '0;
      st_next.sdio_oe = 1'b0;
    end else begin
      case (st_reg.phase)
        scc_pkg::SCC_SPI_INSTR: begin
          if (sclk_rise) begin
            st_next.shift = shifted;
            st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
            if (st_reg.bit_cnt == scc_pkg::INSTR_LAST_BIT) begin
              st_next.bit_cnt = '0;
              st_next.addr = shifted[scc_pkg::ADDR_W-1:0];
              st_next.rd_byte = reg_read(shifted[scc_pkg::ADDR_W-1:0],
                                         st_reg.sync_control,
                                         st_reg.user_clock_options);
              if (shifted[scc_pkg::INSTR_RW_BIT]) begin
                st_next.phase = scc_pkg::SCC_SPI_RDATA;
              end else begin
                st_next.phase = scc_pkg::SCC_SPI_WDATA;
              end
            end
          end
        end
        scc_pkg::SCC_SPI_WDATA: begin
          if (sclk_rise) begin
            st_next.shift = shifted;
            st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
            if (st_reg.bit_cnt == scc_pkg::BYTE_LAST_BIT) begin
              st_next.bit_cnt = '0;
              st_next.addr = st_reg.addr - 1'b1;
              wr_stb = 1'b1;
              wr_byte = shifted[7:0];
            end
          end
        end
        scc_pkg::SCC_SPI_RDATA: begin
          if (sclk_fall) begin
            st_next.sdio_oe = 1'b1;
            st_next.sdio_out = st_reg.rd_byte[7];
            st_next.rd_byte = {st_reg.rd_byte[6:0], 1'b0};
            st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
            if (st_reg.bit_cnt == scc_pkg::BYTE_LAST_BIT) begin
              st_next.bit_cnt = '0;
              st_next.addr = st_reg.addr - 1'b1;
              st_next.rd_byte = reg_read(st_reg.addr - 1'b1,
                                         st_reg.sync_control,
                                         st_reg.user_clock_options);
            end
          end
        end
        default: begin
          st_next.phase = scc_pkg::SCC_SPI_INSTR;
        end
      endcase
    end

    // Sync gating to the clock divider.
    sync_armed = st_reg.sync_control[scc_pkg::MASTER_SYNC_BIT]
      && st_reg.sync_control[scc_pkg::DIV_SYNC_EN_BIT];
    st_next.div_sync = sync_rise && sync_armed;
    if (sync_rise && sync_armed
        && st_reg.sync_control[scc_pkg::ONE_SHOT_BIT]) begin
      // Dropping the gate is what makes every later pulse ignored.
      st_next.sync_control[scc_pkg::DIV_SYNC_EN_BIT] =
        1'b0;
    end

    // A host write lands after the self-clear, so a set in the same cycle
    // is never lost.
    if (wr_stb) begin
      if (st_reg.addr == scc_pkg::SYNC_CONTROL_ADDR) begin
        st_next.sync_control = wr_byte & scc_pkg::SYNC_CONTROL_MASK;
      end else if (st_reg.addr == scc_pkg::USER_CLOCK_OPTIONS_ADDR) begin
        st_next.user_clock_options =
          wr_byte & scc_pkg::USER_CLOCK_OPTIONS_MASK;
      end
    end

    // Output enable pin; with the function off the outputs stay enabled.
    if (st_reg.user_clock_options[scc_pkg::OE_PIN_CTL_BIT]) begin
      st_next.out_en = !st_reg.oen_s;
    end else begin
      st_next.out_en = 1'b1;
    end

    st_next.osc_on =
      st_reg.user_clock_options[scc_pkg::OSC_RUN_BIT]
      || det_link.low_rate;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.sclk_m <= 1'b0;
      st_reg.csb_m <= 1'b1;
      st_reg.csb_s <= 1'b1;
      st_reg.sync_control <= scc_pkg::SYNC_CONTROL_RESET;
      st_reg.user_clock_options <= scc_pkg::USER_CLOCK_OPTIONS_RESET;
      st_reg.out_en <= 1'b1;
      st_reg.phase <= scc_pkg::SCC_SPI_INSTR;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Detector and outputs
  // ==========================================================================
  assign det_link.detect_en =
    st_reg.user_clock_options[scc_pkg::DETECT_EN_BIT];

  scc_rate_det u_rate_det (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .enc_clk_pin (enc_clk_pin),
    .det         (det_link)
  );

  assign sdio_out = st_reg.sdio_out;
  assign sdio_oe = st_reg.sdio_oe;
  assign sdio_pulldown_en =
    !st_reg.user_clock_options[scc_pkg::PULLDOWN_DIS_BIT];
  assign divider_sync_pulse = st_reg.div_sync;
  assign data_out_en = st_reg.out_en;
  assign housekeeping_oscillator_on = st_reg.osc_on;
endmodule
`default_nettype wire

/* testbench/scc_props.sv */
// Concurrent checks on the ports of the sync and clock configuration block.
`timescale 1ns/100ps
`default_nettype none
module scc_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic csb_n,
  input wire logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe,
  input wire logic sdio_pulldown_en,
  input wire logic sync_pin,
  input wire logic divider_sync_pulse,
  input wire logic output_enable_n_pin,
  input wire logic data_out_en,
  input wire logic enc_clk_pin,
  input wire logic housekeeping_oscillator_on
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // ==========================================================================
  // Assertions and cover points
  // ==========================================================================
  chk_pulse_single: assert property (
    divider_sync_pulse |=> !divider_sync_pulse)
    else $error("Sync pulse wider than one cycle.");
  chk_pulse_cause: assert property (
    divider_sync_pulse |-> $past(sync_pin, 2) && !$past(sync_pin, 6))
    else $error("Sync pulse without a rising sync pin.");
  chk_pulldown_frame: assert property (
    $changed(sdio_pulldown_en) |-> !$past(csb_n, 2))
    else $error("Pull-down changed outside a serial frame.");
  // The pin passes two synchronisers and a register, so allow the lag.
  chk_oe_follows: assert property (
    !data_out_en |-> $past(output_enable_n_pin) ||
                     $past(output_enable_n_pin, 5))
    else $error("Data outputs disabled while the pin asks for them.");
  chk_oe_enable: assert property (
    !output_enable_n_pin [*6] |-> data_out_en)
    else $error("Data outputs off with the enable pin low.");
  chk_sdio_frame: assert property (
    sdio_oe |-> !$past(csb_n, 5))
    else $error("Serial data driven outside a frame.");
  chk_sdio_release: assert property (
    $rose(csb_n) |-> ##[1:6] !sdio_oe)
    else $error("Serial data not released after the frame.");
  chk_sdio_on_fall: assert property (
    $changed(sdio_out) |-> !$past(sclk, 2) && !$past(csb_n, 2))
    else $error("Serial read data changed away from a clock fall.");
  cover property (divider_sync_pulse);
  cover property ($rose(housekeeping_oscillator_on));
  cover property (!data_out_en);
  cover property ($rose(sdio_oe));
endmodule
`default_nettype wire

/* testbench/scc_host_model.sv */
// Serial host model driving the three-wire register port.
`timescale 1ns/100ps
`default_nettype none
module scc_host_model (
  input  wire logic ref_clk,
  input  wire logic sdio_out,
  input  wire logic sdio_oe,
  input  wire logic sdio_pulldown_en,
  output logic      sclk,
  output logic      csb_n,
  output logic      sdio_in
);
  logic host_en;
  logic host_val;
  // Released line: pull-down level, else a changed level so stale data shows.
  assign sdio_in = sdio_oe ? sdio_out : host_en ? host_val
                 : sdio_pulldown_en ? 1'b0 : ~host_val;
  initial begin
    sclk = 1'b0;
    csb_n = 1'b1;
    host_en = 1'b0;
    host_val = 1'b0;
  end
  // Phases of five clock cycles keep sclk well under the synchroniser limit.
  task automatic xfer(input logic rw, input logic [12:0] addr,
                      input logic [7:0] wdata, output logic [7:0] rdata);
    logic [23:0] frame;
    frame = {rw, 2'b00, addr, wdata};
    rdata = 8'h00;
    @(posedge ref_clk);
    csb_n <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      @(posedge ref_clk);
      sclk <= 1'b0;
      host_en <= !(rw && i < 8);
      host_val <= frame[i];
      repeat (5) @(posedge ref_clk);
      if (i < 8) rdata = {rdata[6:0], sdio_in};
      sclk <= 1'b1;
      repeat (4) @(posedge ref_clk);
    end
    @(posedge ref_clk);
    sclk <= 1'b0;
    repeat (6) @(posedge ref_clk);
    csb_n <= 1'b1;
    host_en <= 1'b0;
    repeat (10) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

/* testbench/sync_and_clock_config_bench.sv */
// Self-checking bench for the sync and clock configuration block.
`timescale 1ns/100ps
`default_nettype none
`define SCC_CMP(got, exp) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module sync_and_clock_config_bench;
  localparam logic [12:0] SC = scc_pkg::SYNC_CONTROL_ADDR;
  localparam logic [12:0] UC = scc_pkg::USER_CLOCK_OPTIONS_ADDR;
  logic ref_clk, rst, sclk, csb_n, sdio_in, sdio_out, sdio_oe;
  logic sdio_pulldown_en, sync_pin, divider_sync_pulse, data_out_en;
  logic output_enable_n_pin, enc_clk_pin, housekeeping_oscillator_on;
  int fails, total_checks, cycles, pulses, enc_half, enc_cnt;
  logic [7:0] exp_q[$];
  logic [7:0] obs, exp_v, v;
  event obs_ev;
  logic [7:0] sync_set[6] = '{8'h00, 8'h01, 8'h02, 8'h06, 8'h03, 8'h07};
  logic [7:0] sync_cnt[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h01};
  scc_top scc_top_i (.ref_clk(ref_clk), .rst(rst), .sclk(sclk),
    .csb_n(csb_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .sdio_pulldown_en(sdio_pulldown_en),
    .sync_pin(sync_pin), .divider_sync_pulse(divider_sync_pulse),
    .output_enable_n_pin(output_enable_n_pin), .data_out_en(data_out_en),
    .enc_clk_pin(enc_clk_pin),
    .housekeeping_oscillator_on(housekeeping_oscillator_on));
  scc_host_model scc_host_model_i (.ref_clk(ref_clk), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .sdio_pulldown_en(sdio_pulldown_en), .sclk(sclk),
    .csb_n(csb_n), .sdio_in(sdio_in));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Encode clock source; a half period of zero stops it.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (divider_sync_pulse === 1'b1) pulses <= pulses + 1;
    if (enc_half != 0 && enc_cnt >= enc_half - 1) begin
      enc_cnt <= 0;
      enc_clk_pin <= ~enc_clk_pin;
    end else begin
      enc_cnt <= enc_cnt + 1;
    end
    if (cycles == 40000) begin
      fails++;
      conclude();
    end
  end
  always @(obs_ev) begin
    exp_v = exp_q.pop_front();
    `SCC_CMP(obs, exp_v)
  end
  task automatic probe(input logic [7:0] exp, input logic [7:0] got);
    exp_q.push_back(exp);
    obs = got;
    ->obs_ev;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [12:0] a, input logic [7:0] exp);
    logic [7:0] d;
    exp_q.push_back(exp);
    scc_host_model_i.xfer(1'b1, a, 8'h00, d);
    obs = d;
    ->obs_ev;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] unused;
    scc_host_model_i.xfer(1'b0, a, d, unused);
  endtask
  task automatic sync_pulse();
    sync_pin <= 1'b1;
    repeat (6) @(posedge ref_clk);
    sync_pin <= 1'b0;
    repeat (12) @(posedge ref_clk);
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    {sync_pin, output_enable_n_pin, enc_clk_pin} = 3'h0;
    enc_half = 1;
    enc_cnt = 0;
    cycles = 0;
    pulses = 0;
    fails = 0;
    total_checks = 0;
    void'($urandom(32'h1DEF));
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rd(SC, 8'h01);
    rd(UC, 8'h88);
    probe(8'h01, {7'h00, sdio_pulldown_en});
    wr(SC, 8'hFF);
    rd(SC, 8'h07);
    rd(13'h0055, 8'h00);
    foreach (sync_set[k]) begin
      wr(SC, sync_set[k]);
      pulses = 0;
      repeat (2) sync_pulse();
      probe(sync_cnt[k], pulses[7:0]);
    end
    rd(SC, 8'h05);
    output_enable_n_pin <= 1'b1;
    repeat (8) @(posedge ref_clk);
    probe(8'h00, {7'h00, data_out_en});
    wr(UC, 8'h08);
    probe(8'h01, {7'h00, data_out_en});
    output_enable_n_pin <= 1'b0;
    probe(8'h00, {7'h00, housekeeping_oscillator_on});
    // A period of four cycles is exactly 5 MSPS and must not count as slow.
    enc_half = 2;
    repeat (20) @(posedge ref_clk);
    probe(8'h00, {7'h00, housekeeping_oscillator_on});
    enc_half = 3;
    repeat (20) @(posedge ref_clk);
    probe(8'h01, {7'h00, housekeeping_oscillator_on});
    enc_half = 0;
    repeat (20) @(posedge ref_clk);
    probe(8'h01, {7'h00, housekeeping_oscillator_on});
    wr(UC, 8'h00);
    probe(8'h00, {7'h00, housekeeping_oscillator_on});
    // Detector stays on so the run bit is seen to override a fast clock.
    wr(UC, 8'h0C);
    probe(8'h01, {7'h00, housekeeping_oscillator_on});
    enc_half = 1;
    repeat (20) @(posedge ref_clk);
    probe(8'h01, {7'h00, housekeeping_oscillator_on});
    wr(UC, 8'h89);
    probe(8'h00, {7'h00, sdio_pulldown_en});
    repeat (3) begin
      v = 8'($urandom);
      wr(UC, v);
      rd(UC, v & scc_pkg::USER_CLOCK_OPTIONS_MASK);
      probe({7'h00, ~v[0]}, {7'h00, sdio_pulldown_en});
    end
    conclude();
  end
endmodule
bind scc_top scc_props scc_props_i (.ref_clk(ref_clk), .rst(rst),
  .sclk(sclk), .csb_n(csb_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
  .sdio_oe(sdio_oe), .sdio_pulldown_en(sdio_pulldown_en),
  .sync_pin(sync_pin), .divider_sync_pulse(divider_sync_pulse),
  .output_enable_n_pin(output_enable_n_pin), .data_out_en(data_out_en),
  .enc_clk_pin(enc_clk_pin),
  .housekeeping_oscillator_on(housekeeping_oscillator_on));
`default_nettype wire
